// [hdl/tmr_timer16.sv]
// 16-bit timer/counter with free-running and clear-on-match modes and input capture.
//
// Notes on behaviour
// [RL1] Mode zero only counts up and wraps from 0xFFFF to 0x0000.
// [RL2] Free-running overflow flag sets on the tick the counter reaches zero.
// [RL3] Software may write a new count at any time in free-running mode.
// [RL4] Mode twelve clears the count to zero when it equals the capture register.
// [RL5] Mode twelve sets the capture flag each time the count reaches the top.
// [RL6] Top is not double buffered; a top below the count waits for wraparound.
// [RL7] Mode twelve sets the overflow flag on the step from 0xFFFF to zero; a match clear at a top of 0xFFFF does not set it.
// [RL8] Filter bit seven demands four equal capture samples before a change.
// [RL9] Edge bit six: zero captures falling edges, one captures rising edges.
// [RL10] A qualifying edge copies the count into capture and sets the capture flag.
// [RL11] The capture input is disconnected while capture serves as the top.
// [RL12] Mode bit four picks free-running or clear-on-match; overflow at maximum.
// [RL13] Clock select: 000 stop, 001 core clock, 110/111 external falling/rising.
// [RL14] External pin transitions advance the count whatever the pin direction.
// [RL15] Sixteen-bit values pass through one shared high-byte holding register.
// [RL16] A count write blocks the compare match on the next timer tick.
// [RL17] Capture enable bit five with global enable raises the capture interrupt.
// [RL18] Unused control and mask bits ignore writes and read as zero.
// [RL19] Overflow enable bit zero with global enable raises the overflow interrupt.
// [RL20] Each flag clears on interrupt service or on a written one.
// [RL21] Count low read latches the high byte; low write loads high from holding.
// [RL22] A count write wins over clear or count in the same cycle.
// [RL23] Reserved clock select codes stop the counter.
// [RL24] All control, mask, flag, count and capture state resets to zero.
`timescale 1ns/1ps
module tmr_timer16
  import tmr_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire tmr_io_req_t  io_req,
  output logic [7:0]        io_rdata,
  input  wire logic         global_irq_enable,
  input  wire tmr_irq_ack_t irq_ack,
  output logic              capture_irq,
  output logic              overflow_irq,
  input  wire logic         capture_input_pin,
  input  wire logic         external_count_pin
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    tmr_control_t ctrl;
    logic         capture_irq_enable;
    logic         overflow_irq_enable;
    logic         capture_flag;
    logic         overflow_flag;
    logic [15:0]  count_value;
    logic [15:0]  capture_value;
    logic [7:0]   temp_high;
    logic         match_block;
    logic         cap_prev;
    logic         ext_prev;
    logic [7:0]   rdata;
    logic         capture_irq;
    logic         overflow_irq;
  } tmr_state_t;

  tmr_state_t q;
  tmr_state_t next_q;

  logic cap_level;
  logic ext_level;
  logic ctc_mode;
  logic tick;
  logic count_write;
  logic cap_write;
  logic match_hit;
  logic cap_edge;
  logic ext_edge;
  logic [7:0] read_mux;

  // ---------------------------------------------------------------------------
  // Pin conditioning
  // ---------------------------------------------------------------------------
  // [RL8] capture filter
  tmr_pin_filter u_capture_filter (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .pin_in    (capture_input_pin),
    .filter_en (q.ctrl.capture_filter_enable),
    .level     (cap_level)
  );

  // The count pin is always read, so a pin driven as an output still clocks the counter.
  tmr_pin_filter u_count_sampler (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .pin_in    (external_count_pin),
    .filter_en (1'b0),
    .level     (ext_level)
  );

  // ---------------------------------------------------------------------------
  // Timer tick and decode
  // ---------------------------------------------------------------------------
  assign ctc_mode    = q.ctrl.waveform_mode_bit;
  assign count_write = io_req.wr && (io_req.addr == TMR_ADDR_COUNT_LOW);
  assign cap_write   = io_req.wr && (io_req.addr == TMR_ADDR_CAPTURE_LOW);

  // [RL14] pin edges
  assign ext_edge = (q.ctrl.clock_select == TMR_CS_EXT_RISE) ? (ext_level && !q.ext_prev)
                                                             : (!ext_level && q.ext_prev);

  // [RL13] clock select
  always_comb begin
    case (q.ctrl.clock_select)
      TMR_CS_IO_CLK:   tick = 1'b1;
      TMR_CS_EXT_FALL: tick = ext_edge;
      TMR_CS_EXT_RISE: tick = ext_edge;
      // [RL23] reserved codes stop
      default:         tick = 1'b0;
    endcase
  end

  // [RL6] live top compare
  // The top is compared directly, so lowering it below the count misses the match.
  assign match_hit = ctc_mode && tick && !q.match_block && (q.count_value == q.capture_value);

  // [RL9] edge select
  assign cap_edge = q.ctrl.capture_edge_select ? (cap_level && !q.cap_prev)
                                               : (!cap_level && q.cap_prev);

  // ---------------------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------------------
  always_comb begin
    case (io_req.addr)
      // [RL18] reserved bits zero
      TMR_ADDR_CONTROL_B: begin
        read_mux = 8'h00;
        read_mux[TMR_BIT_FILTER_EN] = q.ctrl.capture_filter_enable;
        read_mux[TMR_BIT_EDGE_SEL] = q.ctrl.capture_edge_select;
        read_mux[TMR_BIT_MODE] = q.ctrl.waveform_mode_bit;
        read_mux[2:0] = q.ctrl.clock_select;
      end
      TMR_ADDR_COUNT_LOW:    read_mux = q.count_value[7:0];
      TMR_ADDR_COUNT_HIGH:   read_mux = q.temp_high;
      TMR_ADDR_CAPTURE_LOW:  read_mux = q.capture_value[7:0];
      TMR_ADDR_CAPTURE_HIGH: read_mux = q.temp_high;
      TMR_ADDR_IRQ_MASK: begin
        read_mux = 8'h00;
        read_mux[TMR_BIT_CAPTURE] = q.capture_irq_enable;
        read_mux[TMR_BIT_OVERFLOW] = q.overflow_irq_enable;
      end
      TMR_ADDR_FLAGS: begin
        read_mux = 8'h00;
        read_mux[TMR_BIT_CAPTURE] = q.capture_flag;
        read_mux[TMR_BIT_OVERFLOW] = q.overflow_flag;
      end
      default:               read_mux = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.cap_prev = cap_level;
    next_q.ext_prev = ext_level;
    next_q.rdata = io_req.rd ? read_mux : q.rdata;

    // [RL15] shared holding byte
    if (io_req.wr && (io_req.addr == TMR_ADDR_COUNT_HIGH ||
                      io_req.addr == TMR_ADDR_CAPTURE_HIGH)) begin
      next_q.temp_high = io_req.wdata;
    end
    // [RL21] low read latches high
    if (io_req.rd && io_req.addr == TMR_ADDR_COUNT_LOW) begin
      next_q.temp_high = q.count_value[15:8];
    end
    if (io_req.rd && io_req.addr == TMR_ADDR_CAPTURE_LOW) begin
      next_q.temp_high = q.capture_value[15:8];
    end

    // [RL18] masked control writes
    if (io_req.wr && io_req.addr == TMR_ADDR_CONTROL_B) begin
      next_q.ctrl.capture_filter_enable = io_req.wdata[TMR_BIT_FILTER_EN];
      next_q.ctrl.capture_edge_select = io_req.wdata[TMR_BIT_EDGE_SEL];
      // [RL12] mode bit
      next_q.ctrl.waveform_mode_bit = io_req.wdata[TMR_BIT_MODE];
      next_q.ctrl.clock_select = io_req.wdata[2:0];
    end
    if (io_req.wr && io_req.addr == TMR_ADDR_IRQ_MASK) begin
      next_q.capture_irq_enable = io_req.wdata[TMR_BIT_CAPTURE];
      next_q.overflow_irq_enable = io_req.wdata[TMR_BIT_OVERFLOW];
    end

    // [RL20] clear by ack or one
    if (irq_ack.capture_ack ||
        (io_req.wr && io_req.addr == TMR_ADDR_FLAGS && io_req.wdata[TMR_BIT_CAPTURE])) begin
      next_q.capture_flag = 1'b0;
    end
    if (irq_ack.overflow_ack ||
        (io_req.wr && io_req.addr == TMR_ADDR_FLAGS && io_req.wdata[TMR_BIT_OVERFLOW])) begin
      next_q.overflow_flag = 1'b0;
    end

    // [RL16] block next match
    if (count_write) begin
      next_q.match_block = 1'b1;
    end else if (tick) begin
      next_q.match_block = 1'b0;
    end

    // [RL22] write wins
    if (count_write) begin
      // [RL3] write anytime
      next_q.count_value = {q.temp_high, io_req.wdata};
    end else if (match_hit) begin
      // [RL4] clear on match
      next_q.count_value = TMR_COUNT_BOTTOM;
    end else if (tick) begin
      // [RL1] up count wraps
      next_q.count_value = q.count_value + 16'h0001;
    end

    // Flag sets come after the clears so an event in the clearing cycle survives.
    // [RL2] overflow on wrap
    // [RL7] overflow both modes
    if (!count_write && !match_hit && tick && q.count_value == TMR_COUNT_MAX) begin
      next_q.overflow_flag = 1'b1;
    end
    // [RL5] flag at top
    if (!count_write && match_hit) begin
      next_q.capture_flag = 1'b1;
    end

    // Capture writes only take effect while the register acts as the top.
    if (cap_write && ctc_mode) begin
      next_q.capture_value = {q.temp_high, io_req.wdata};
    end else if (!ctc_mode && cap_edge) begin
      // [RL11] capture disconnected
      // [RL10] time-stamp event
      next_q.capture_value = q.count_value;
      next_q.capture_flag = 1'b1;
    end

    // [RL17] capture interrupt
    next_q.capture_irq = next_q.capture_flag && next_q.capture_irq_enable && global_irq_enable;
    // [RL19] overflow interrupt
    next_q.overflow_irq = next_q.overflow_flag && next_q.overflow_irq_enable &&
                          global_irq_enable;
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // [RL24] zero reset
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign io_rdata     = q.rdata;
  assign capture_irq  = q.capture_irq;
  assign overflow_irq = q.overflow_irq;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  AST_WRAP_ZERO: assert property ( // [RL1]
    (!ctc_mode && tick && !count_write && q.count_value == TMR_COUNT_MAX)
      |=> (q.count_value == TMR_COUNT_BOTTOM))
    else $error("free-running count did not wrap to zero");

  AST_OVF_SET: assert property ( // [RL2]
    (tick && !count_write && !match_hit && q.count_value == TMR_COUNT_MAX)
      |=> q.overflow_flag ##0 q.count_value == TMR_COUNT_BOTTOM)
    else $error("overflow flag not set with wrap");

  AST_COUNT_WRITE: assert property ( // [RL22]
    count_write |=> (q.count_value == {$past(q.temp_high), $past(io_req.wdata)}))
    else $error("count write did not take priority");

  AST_CTC_CLEAR: assert property ( // [RL4]
    match_hit && !count_write |=> (q.count_value == TMR_COUNT_BOTTOM) && q.capture_flag)
    else $error("match did not clear count and set capture flag");

  AST_MATCH_BLOCK: assert property ( // [RL16]
    count_write ##1 (tick && !count_write) |-> !match_hit)
    else $error("match not blocked after count write");

  AST_STOPPED: assert property ( // [RL23]
    (q.ctrl.clock_select inside {3'b000, 3'b010, 3'b011, 3'b100, 3'b101} && !count_write)
      |=> $stable(q.count_value))
    else $error("counter advanced with no clock source");

  AST_NO_CAPTURE_CTC: assert property ( // [RL11]
    (ctc_mode && !cap_write) |=> $stable(q.capture_value))
    else $error("capture register changed while used as top");

  AST_CAPTURE_EDGE: assert property ( // [RL10]
    (!ctc_mode && cap_edge && !cap_write)
      |=> (q.capture_value == $past(q.count_value)) && q.capture_flag)
    else $error("capture edge did not time-stamp");

  AST_RESERVED_ZERO: assert property ( // [RL18]
    (io_req.rd && io_req.addr == TMR_ADDR_CONTROL_B) |=> ((q.rdata & 8'h28) == 8'h00))
    else $error("reserved control bits read non-zero");

  AST_CAP_IRQ: assert property ( // [RL17]
    (q.capture_flag && q.capture_irq_enable && global_irq_enable && !irq_ack.capture_ack &&
     !io_req.wr) |=> capture_irq)
    else $error("capture interrupt not raised");

  AST_OVF_IRQ: assert property ( // [RL19]
    (q.overflow_flag && q.overflow_irq_enable && global_irq_enable && !irq_ack.overflow_ack &&
     !io_req.wr) |=> overflow_irq)
    else $error("overflow interrupt not raised");

  AST_TEMP_LATCH: assert property ( // [RL21]
    (io_req.rd && io_req.addr == TMR_ADDR_COUNT_LOW)
      |=> (q.temp_high == $past(q.count_value[15:8])))
    else $error("count low read did not latch the high byte");

  AST_HIGH_HOLD: assert property ( // [RL15]
    (io_req.wr && !io_req.rd && io_req.addr == TMR_ADDR_COUNT_HIGH)
      |=> (q.temp_high == $past(io_req.wdata)))
    else $error("high byte write did not reach the holding byte");

  AST_OVF_CLEAR: assert property ( // [RL20]
    (irq_ack.overflow_ack && !tick) |=> !q.overflow_flag)
    else $error("overflow flag not cleared by service");

  AST_CAP_CLEAR: assert property ( // [RL20]
    (irq_ack.capture_ack && !cap_edge && !match_hit) |=> !q.capture_flag)
    else $error("capture flag not cleared by service");

  AST_MASK_ZERO: assert property ( // [RL18]
    (io_req.rd && io_req.addr == TMR_ADDR_IRQ_MASK) |=> ((q.rdata & 8'hDE) == 8'h00))
    else $error("reserved mask bits read non-zero");

endmodule : tmr_timer16

// [hdl/tmr_pkg.sv]
// Package of constants and carrier types for the 16-bit timer/counter.
package tmr_pkg;

  // ---------------------------------------------------------------------------
  // Register locations on the 8-bit I/O port
  // ---------------------------------------------------------------------------
  localparam logic [2:0] TMR_ADDR_CONTROL_B = 3'h0;
  localparam logic [2:0] TMR_ADDR_COUNT_LOW = 3'h1;
  localparam logic [2:0] TMR_ADDR_COUNT_HIGH = 3'h2;
  localparam logic [2:0] TMR_ADDR_CAPTURE_LOW = 3'h3;
  localparam logic [2:0] TMR_ADDR_CAPTURE_HIGH = 3'h4;
  localparam logic [2:0] TMR_ADDR_IRQ_MASK = 3'h5;
  localparam logic [2:0] TMR_ADDR_FLAGS = 3'h6;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int TMR_BIT_FILTER_EN = 7;
  localparam int TMR_BIT_EDGE_SEL = 6;
  localparam int TMR_BIT_MODE = 4;
  localparam int TMR_BIT_CAPTURE = 5;
  localparam int TMR_BIT_OVERFLOW = 0;

  // Writable bits; every other bit ignores writes and reads as zero.
  localparam logic [7:0] TMR_CONTROL_WMASK = 8'hD7;
  localparam logic [7:0] TMR_MASK_WMASK = 8'h21;

  // ---------------------------------------------------------------------------
  // Reset values and counter limits
  // ---------------------------------------------------------------------------
  localparam logic [7:0] TMR_CONTROL_RESET = 8'h00;
  localparam logic [7:0] TMR_MASK_RESET = 8'h00;
  localparam logic [15:0] TMR_COUNT_RESET = 16'h0000;
  localparam logic [15:0] TMR_COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] TMR_COUNT_BOTTOM = 16'h0000;

  // Number of equal samples the capture noise filter demands.
  localparam int TMR_FILTER_SAMPLES = 4;

  // ---------------------------------------------------------------------------
  // Clock select codes
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    TMR_CS_STOPPED  = 3'b000,
    TMR_CS_IO_CLK   = 3'b001,
    TMR_CS_EXT_FALL = 3'b110,
    TMR_CS_EXT_RISE = 3'b111
  } tmr_clock_select_t;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } tmr_io_req_t;

  typedef struct packed {
    logic capture_ack;
    logic overflow_ack;
  } tmr_irq_ack_t;

  typedef struct packed {
    logic       capture_filter_enable;
    logic       capture_edge_select;
    logic       waveform_mode_bit;
    logic [2:0] clock_select;
  } tmr_control_t;

endpackage : tmr_pkg

// [hdl/tmr_pin_filter.sv]
// Pin sampler with optional four-sample noise filter.
`timescale 1ns/1ps
module tmr_pin_filter
  import tmr_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic pin_in,
  input  wire logic filter_en,
  output logic      level
);

  typedef struct packed {
    logic [TMR_FILTER_SAMPLES-1:0] hist;
    logic                          level;
  } tmr_filt_state_t;

  tmr_filt_state_t q;
  tmr_filt_state_t next_q;

  always_comb begin
    next_q = q;
    next_q.hist = {q.hist[TMR_FILTER_SAMPLES-2:0], pin_in};
    if (!filter_en) begin
      next_q.level = pin_in;
    end else if (&q.hist) begin
      next_q.level = 1'b1;
    end else if (~|q.hist) begin
      next_q.level = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign level = q.level;

endmodule : tmr_pin_filter

// [bench/tmr_pin_model.sv]
// Model of the external parts that drive the capture pin and the count pin.
`timescale 1ns/1ps
module tmr_pin_model (
  input  wire logic core_clk,
  output logic      capture_input_pin,
  output logic      external_count_pin
);
  initial begin
    capture_input_pin  = 1'b0;
    external_count_pin = 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Count pin
  // ---------------------------------------------------------------------------
  // software-driven count pin
  task automatic count_pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      #1 external_count_pin = 1'b1;
      repeat (2) @(posedge core_clk);
      #1 external_count_pin = 1'b0;
      @(posedge core_clk);
    end
    // The sampler and edge detector settle on the first of three more edges.
    repeat (3) @(posedge core_clk);
  endtask : count_pulses

  // ---------------------------------------------------------------------------
  // Capture pin
  // ---------------------------------------------------------------------------
  task automatic set_capture(input logic v, input int hold);
    @(posedge core_clk);
    #1 capture_input_pin = v;
    repeat (hold) @(posedge core_clk);
  endtask : set_capture

  task automatic glitch_capture(input int width);
    logic cur;
    cur = capture_input_pin;
    set_capture(~cur, width);
    set_capture(cur, 10);
  endtask : glitch_capture
endmodule : tmr_pin_model

// [bench/tb_tmr_timer16.sv]
// Self-checking testbench of the 16-bit timer/counter.
`timescale 1ns/1ps
module tb_tmr_timer16
  import tmr_pkg::*;
;
  logic         core_clk;
  logic         arst_n;
  tmr_io_req_t  io_req;
  logic [7:0]   io_rdata;
  logic         global_irq_enable;
  tmr_irq_ack_t irq_ack;
  logic         capture_irq;
  logic         overflow_irq;
  logic         capture_input_pin;
  logic         external_count_pin;
  int           err_count;
  int           compares;
  logic [15:0]  v;

  tmr_timer16 DUT (
    .core_clk(core_clk), .arst_n(arst_n), .io_req(io_req), .io_rdata(io_rdata),
    .global_irq_enable(global_irq_enable), .irq_ack(irq_ack),
    .capture_irq(capture_irq), .overflow_irq(overflow_irq),
    .capture_input_pin(capture_input_pin), .external_count_pin(external_count_pin)
  );

  tmr_pin_model pins (
    .core_clk(core_clk), .capture_input_pin(capture_input_pin),
    .external_count_pin(external_count_pin)
  );

  always #5 core_clk = ~core_clk;

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 io_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge core_clk);
    #1 io_req = '0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1 io_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    #1 io_req = '0;
    d = io_rdata;
  endtask : rd

  // High location first, low second, as the shared holding byte demands.
  task automatic wr16(input logic [2:0] lo, input logic [15:0] d);
    wr(lo + 3'h1, d[15:8]);
    wr(lo, d[7:0]);
  endtask : wr16

  task automatic rd16(input logic [2:0] lo, output logic [15:0] d);
    rd(lo, d[7:0]);
    rd(lo + 3'h1, d[15:8]);
  endtask : rd16

  task automatic ack(input logic cap, input logic ovf);
    @(posedge core_clk);
    #1 irq_ack = '{capture_ack: cap, overflow_ack: ovf};
    @(posedge core_clk);
    #1 irq_ack = '0;
    repeat (2) @(posedge core_clk);
  endtask : ack

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic s_reset_and_regs();
    logic [7:0] b;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), b);
      check("reset read", {8'h00, b}, 16'h0000);
    end
    wr(TMR_ADDR_CONTROL_B, 8'hFA);
    rd(TMR_ADDR_CONTROL_B, b);
    check("control bits", {8'h00, b}, 16'h00D2);
    wr(TMR_ADDR_IRQ_MASK, 8'hFF);
    rd(TMR_ADDR_IRQ_MASK, b);
    check("mask bits", {8'h00, b}, 16'h0021);
    wr(3'h7, 8'hFF);
    rd(3'h7, b);
    check("unmapped read", {8'h00, b}, 16'h0000);
    wr(TMR_ADDR_CONTROL_B, 8'h00);
    wr(TMR_ADDR_IRQ_MASK, 8'h00);
    wr16(TMR_ADDR_COUNT_LOW, 16'h1234);
    rd16(TMR_ADDR_COUNT_LOW, v);
    check("count pair", v, 16'h1234);
  endtask : s_reset_and_regs

  task automatic s_clock_select();
    // Twelve core-clock ticks: ten idle edges plus the two edges of the stopping write.
    wr16(TMR_ADDR_COUNT_LOW, 16'h0000);
    wr(TMR_ADDR_CONTROL_B, 8'h01);
    repeat (10) @(posedge core_clk);
    wr(TMR_ADDR_CONTROL_B, 8'h00);
    rd16(TMR_ADDR_COUNT_LOW, v);
    check("core clock count", v, 16'h000C);
    wr16(TMR_ADDR_COUNT_LOW, 16'h0000);
    wr(TMR_ADDR_CONTROL_B, 8'h07);
    pins.count_pulses(5);
    rd16(TMR_ADDR_COUNT_LOW, v);
    check("rising count", v, 16'h0005);
    wr(TMR_ADDR_CONTROL_B, 8'h06);
    pins.count_pulses(3);
    rd16(TMR_ADDR_COUNT_LOW, v);
    check("falling count", v, 16'h0008);
    // Every stopped or reserved code must leave the count alone.
    for (int c = 0; c < 6; c++) begin
      if (c != 1) begin
        wr(TMR_ADDR_CONTROL_B, 8'(c));
        pins.count_pulses(2);
        rd16(TMR_ADDR_COUNT_LOW, v);
        check("stopped count", v, 16'h0008);
      end
    end
  endtask : s_clock_select

  task automatic s_overflow();
    logic [7:0] b;
    wr16(TMR_ADDR_COUNT_LOW, 16'hFFFE);
    wr(TMR_ADDR_CONTROL_B, 8'h07);
    pins.count_pulses(2);
    rd16(TMR_ADDR_COUNT_LOW, v);
    check("wrap count", v, 16'h0000);
    rd(TMR_ADDR_FLAGS, b);
    check("overflow flag", {8'h00, b}, 16'h0001);
    wr(TMR_ADDR_IRQ_MASK, 8'h01);
    global_irq_enable = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 check("overflow irq", {15'h0, overflow_irq}, 16'h0001);
    global_irq_enable = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 check("irq masked", {15'h0, overflow_irq}, 16'h0000);
    ack(1'b0, 1'b1);
    rd(TMR_ADDR_FLAGS, b);
    check("ack clear", {8'h00, b}, 16'h0000);
  endtask : s_overflow

  task automatic s_clear_on_match();
    logic [7:0] b;
    wr(TMR_ADDR_CONTROL_B, 8'h10);
    wr16(TMR_ADDR_CAPTURE_LOW, 16'h0003);
    wr16(TMR_ADDR_COUNT_LOW, 16'h0000);
    wr(TMR_ADDR_CONTROL_B, 8'h17);
    pins.count_pulses(4);
    rd16(TMR_ADDR_COUNT_LOW, v);
    check("match clear", v, 16'h0000);
    rd(TMR_ADDR_FLAGS, b);
    check("top flag", {8'h00, b}, 16'h0020);
    wr(TMR_ADDR_FLAGS, 8'h20);
    wr16(TMR_ADDR_COUNT_LOW, 16'h0003);
    pins.count_pulses(1);
    rd16(TMR_ADDR_COUNT_LOW, v);
    check("match blocked", v, 16'h0004);
    // Top now below the count; the match is missed until wraparound.
    pins.count_pulses(1);
    rd16(TMR_ADDR_COUNT_LOW, v);
    check("missed top", v, 16'h0005);
    pins.set_capture(1'b1, 8);
    pins.set_capture(1'b0, 8);
    rd16(TMR_ADDR_CAPTURE_LOW, v);
    check("capture off", v, 16'h0003);
    rd(TMR_ADDR_FLAGS, b);
    check("no capture flag", {8'h00, b}, 16'h0000);
    wr16(TMR_ADDR_COUNT_LOW, 16'hFFFF);
    pins.count_pulses(1);
    rd(TMR_ADDR_FLAGS, b);
    check("top overflow", {8'h00, b}, 16'h0001);
    wr(TMR_ADDR_FLAGS, 8'h01);
    wr(TMR_ADDR_CONTROL_B, 8'h00);
  endtask : s_clear_on_match

  task automatic s_capture();
    logic [7:0] b;
    wr16(TMR_ADDR_COUNT_LOW, 16'h0123);
    wr(TMR_ADDR_CONTROL_B, 8'h40);
    wr(TMR_ADDR_IRQ_MASK, 8'h20);
    global_irq_enable = 1'b1;
    pins.set_capture(1'b1, 8);
    rd16(TMR_ADDR_CAPTURE_LOW, v);
    check("rising capture", v, 16'h0123);
    check("capture irq", {15'h0, capture_irq}, 16'h0001);
    wr(TMR_ADDR_FLAGS, 8'h20);
    repeat (2) @(posedge core_clk);
    #1 check("irq cleared", {15'h0, capture_irq}, 16'h0000);
    wr16(TMR_ADDR_COUNT_LOW, 16'h0456);
    pins.set_capture(1'b0, 8);
    rd(TMR_ADDR_FLAGS, b);
    check("falling ignored", {8'h00, b}, 16'h0000);
    wr(TMR_ADDR_CONTROL_B, 8'h00);
    pins.set_capture(1'b1, 8);
    pins.set_capture(1'b0, 8);
    rd16(TMR_ADDR_CAPTURE_LOW, v);
    check("falling capture", v, 16'h0456);
    ack(1'b1, 1'b0);
    wr16(TMR_ADDR_COUNT_LOW, 16'h0789);
    wr(TMR_ADDR_CONTROL_B, 8'hC0);
    // A hold of two edges leaves the pin high for three samples only.
    pins.glitch_capture(2);
    rd(TMR_ADDR_FLAGS, b);
    check("glitch rejected", {8'h00, b}, 16'h0000);
    pins.set_capture(1'b1, 10);
    rd16(TMR_ADDR_CAPTURE_LOW, v);
    check("filtered capture", v, 16'h0789);
  endtask : s_capture

  // Reset in mid-run, with the capture interrupt standing, must clear everything again.
  task automatic s_mid_reset();
    logic [7:0] b;
    @(posedge core_clk);
    #1 arst_n = 1'b0;
    #1 check("irq in reset", {14'h0, capture_irq, overflow_irq}, 16'h0000);
    repeat (2) @(posedge core_clk);
    #1 arst_n = 1'b1;
    for (int a = 0; a < 7; a++) begin
      rd(3'(a), b);
      check("reset again", {8'h00, b}, 16'h0000);
    end
  endtask : s_mid_reset

  // ---------------------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------------------
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  initial begin
    #300000;
    err_count++;
    complete_run();
  end

  initial begin
    core_clk          = 1'b0;
    arst_n            = 1'b0;
    io_req            = '0;
    irq_ack           = '0;
    global_irq_enable = 1'b0;
    err_count         = 0;
    compares          = 0;
    repeat (20) @(posedge core_clk);
    #1 arst_n = 1'b1;
    s_reset_and_regs();
    s_clock_select();
    s_overflow();
    s_clear_on_match();
    s_capture();
    s_mid_reset();
    complete_run();
  end
endmodule : tb_tmr_timer16
